/* pkg/msc_pkg.sv */
// Shared constants and types for the module sideband control link
package msc_pkg;
  // Reset pulse filter: least low time on the reset input
  localparam int RESET_MIN_NS = 1000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RESET_MIN_CNT = 8'(RESET_MIN_CYC);
  // Module initialisation time after a reset, kept short
  localparam int INIT_NS = 2000;
  localparam int INIT_CYC = INIT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] INIT_CNT = 8'(INIT_CYC);
  // Host reset pulse length, twice the minimum for margin
  localparam logic [7:0] HOST_RST_CNT = 8'(2 * RESET_MIN_CYC);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;

  // Device reset sequencer states, Gray along the path
  typedef enum logic [1:0] {
    MSC_ST_RESET = 2'b00,
    MSC_ST_INIT = 2'b01,
    MSC_ST_READY = 2'b11
  } msc_dev_state_type;
endpackage : msc_pkg

/* pkg/msc_if.sv */
// Sideband pin bundle between host board and pluggable module
`timescale 1ns/1ns
interface msc_if;
  logic module_select_n;
  logic module_reset_n;
  logic low_power_select;
  logic module_present_n;
  logic int_oe;
  logic scl;
  logic sda_host_oe;
  logic sda_dev_oe;
  // Open-drain lines resolved here from the pull-down enables
  wire module_interrupt_n = ~int_oe;
  wire sda = ~(sda_host_oe | sda_dev_oe);

  modport device (
    input module_select_n, module_reset_n, low_power_select, scl, sda,
    output module_present_n, int_oe, sda_dev_oe
  );
  modport host (
    output module_select_n, module_reset_n, low_power_select, scl,
    output sda_host_oe,
    input module_present_n, module_interrupt_n, sda
  );
endinterface : msc_if

/* core/msc_device.sv */
// Module end: select gating, reset filter, interrupt and power mode
//
// Behaviour
// - Serve management bus only while selected
// - Host gives each module own select
// - Memory map reached over clock and data
// - Long reset low restores all defaults
// - Host ignores status until reset completes
// - Completion raises interrupt, clears not-ready
// - Power-up raises completion interrupt unprompted
// - Low-power input picks power limit
// - Inserted module grounds presence line
// - Interrupt pulled low on fault/critical status
// - Host reads status to find cause
// - Interrupt line only pulled low or released
`timescale 1ns/1ns
module msc_device
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Pins toward the host
  msc_if.device pins,
  // Local management engine
  output logic mgmt_enable,
  input wire logic mgmt_sda_pull,
  output logic scl_sync,
  output logic sda_sync,
  // Status and faults
  input wire logic fault_event,
  input wire logic int_ack,
  output logic data_not_ready,
  output logic low_power_mode,
  output logic settings_default
);

  // ==========
  // Two-stage synchronisers for every incoming pin
  logic [4:0] pin_raw;
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  assign pin_raw = {pins.module_select_n, pins.module_reset_n,
                    pins.low_power_select, pins.scl, pins.sda};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          meta_ff[gi] <= 1'b1;
          sync_ff[gi] <= 1'b1;
        end else begin
          meta_ff[gi] <= pin_raw[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  wire sel_n_s = sync_ff[4];
  wire rst_n_s = sync_ff[3];
  wire lpm_s = sync_ff[2];

  // ==========
  // Bus traffic qualified by select; deselected leaves SDA alone
  assign mgmt_enable = ~sel_n_s;
  assign scl_sync = sync_ff[1];
  assign sda_sync = sync_ff[0];
  logic sda_oe_ff;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sda_oe_ff <= 1'b0;
    end else begin
      sda_oe_ff <= mgmt_sda_pull & ~sel_n_s;
    end
  end
  assign pins.sda_dev_oe = sda_oe_ff;

  // Presence strap: inserted module ties the line low
  assign pins.module_present_n = 1'b0;

  // Low-power select steers the power limit
  logic lpm_ff;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lpm_ff <= 1'b1;
    end else begin
      lpm_ff <= lpm_s;
    end
  end
  assign low_power_mode = lpm_ff;

  // ==========
  // Reset filter: glitches shorter than the minimum are ignored
  logic [7:0] low_cnt_ff;
  logic [7:0] nxt_low_cnt;
  wire rst_long = (low_cnt_ff >= RESET_MIN_CNT);
  assign nxt_low_cnt = rst_n_s ? CNT_ZERO :
                       (rst_long ? low_cnt_ff : low_cnt_ff + CNT_ONE);
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      low_cnt_ff <= CNT_ZERO;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  // Reset sequencer; power-up enters the same path as a pin reset
  msc_dev_state_type state_ff;
  msc_dev_state_type nxt_state;
  logic [7:0] init_cnt_ff;
  wire init_done = (init_cnt_ff == CNT_ZERO);
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      MSC_ST_RESET: if (!rst_long) nxt_state = MSC_ST_INIT;
      MSC_ST_INIT: begin
        if (rst_long) nxt_state = MSC_ST_RESET;
        else if (init_done) nxt_state = MSC_ST_READY;
      end
      MSC_ST_READY: if (rst_long) nxt_state = MSC_ST_RESET;
      default: nxt_state = MSC_ST_RESET;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_ff <= MSC_ST_RESET;
      init_cnt_ff <= INIT_CNT;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != MSC_ST_INIT) begin
        init_cnt_ff <= INIT_CNT;
      end else if (!init_done) begin
        init_cnt_ff <= init_cnt_ff - CNT_ONE;
      end
    end
  end
  assign settings_default = (state_ff == MSC_ST_RESET);

  // ==========
  // Completion sets interrupt and clears not-ready; set beats ack
  wire completion = (state_ff == MSC_ST_INIT) &&
                    (nxt_state == MSC_ST_READY);
  logic dnr_ff;
  logic int_ff;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dnr_ff <= 1'b1;
      int_ff <= 1'b0;
    end else begin
      if (state_ff != MSC_ST_READY && !completion) begin
        dnr_ff <= 1'b1;
      end else if (completion) begin
        dnr_ff <= 1'b0;
      end
      if (state_ff == MSC_ST_RESET) begin
        int_ff <= 1'b0;
      end else if (completion || fault_event) begin
        int_ff <= 1'b1;
      end else if (int_ack) begin
        int_ff <= 1'b0;
      end
    end
  end
  assign data_not_ready = dnr_ff;
  // Open drain: only pull low or release
  assign pins.int_oe = int_ff;

endmodule // msc_device

/* core/msc_host.sv */
// Host end: drives select, reset and power mode; watches interrupt
`timescale 1ns/1ns
module msc_host
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Pins toward the module
  msc_if.host pins,
  // Host controller requests
  input wire logic select_req,
  input wire logic reset_req,
  input wire logic low_power_req,
  input wire logic scl_drive,
  input wire logic sda_pull,
  // Observed state
  output logic present,
  output logic int_pending,
  output logic status_valid,
  output logic reset_busy,
  output logic sda_in
);

  // ==========
  // Synchronise module-driven pins
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic [2:0] pin_raw;
  assign pin_raw = {pins.module_present_n, pins.module_interrupt_n,
                    pins.sda};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          meta_ff[gi] <= 1'b1;
          sync_ff[gi] <= 1'b1;
        end else begin
          meta_ff[gi] <= pin_raw[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  // Low presence means a module sits in the cage
  assign present = ~sync_ff[2];
  wire int_low = ~sync_ff[1];
  assign sda_in = sync_ff[0];

  // ==========
  // Reset pulse held past the module's minimum
  logic [7:0] rst_cnt_ff;
  wire rst_active = (rst_cnt_ff != CNT_ZERO);
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rst_cnt_ff <= CNT_ZERO;
    end else if (reset_req && !rst_active) begin
      rst_cnt_ff <= HOST_RST_CNT;
    end else if (rst_active) begin
      rst_cnt_ff <= rst_cnt_ff - CNT_ONE;
    end
  end

  // Status ignored from reset until completion interrupt
  logic wait_ff;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wait_ff <= 1'b1;
    end else if (rst_active || !present) begin
      wait_ff <= 1'b1;
    end else if (int_low) begin
      wait_ff <= 1'b0;
    end
  end
  assign reset_busy = wait_ff;
  assign status_valid = ~wait_ff;
  // Interrupt tells the controller to read status over the bus
  assign int_pending = int_low & ~wait_ff;

  // ==========
  // Pin drives: select, power mode, SCL and SDA registered; reset decoded from the pulse counter
  logic sel_ff;
  logic lpm_ff;
  logic scl_ff;
  logic sda_ff;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sel_ff <= 1'b1;
      lpm_ff <= 1'b1;
      scl_ff <= 1'b1;
      sda_ff <= 1'b0;
    end else begin
      sel_ff <= ~select_req;
      lpm_ff <= low_power_req;
      scl_ff <= scl_drive;
      sda_ff <= sda_pull & select_req;
    end
  end
  assign pins.module_select_n = sel_ff;
  assign pins.module_reset_n = ~rst_active;
  assign pins.low_power_select = lpm_ff;
  assign pins.scl = scl_ff;
  assign pins.sda_host_oe = sda_ff;

endmodule // msc_host

/* test/msc_sva.sv */
// Checker on the sideband pins between host and module
`timescale 1ns/1ns
module msc_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Sideband pins
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_select,
  input wire logic module_present_n,
  input wire logic int_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe
);
  logic [7:0] low_ff;
  logic [7:0] nxt_low;
  // ==========
  // Helpers
  // Run length of reset low, saturating so it never wraps
  assign nxt_low = module_reset_n ? 8'h00 :
    (low_ff == 8'hFF) ? low_ff : low_ff + 8'h01;
  always_ff @(posedge core_clk) begin
    low_ff <= rstn ? nxt_low : 8'h00;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ==========
  // Assertions
  a_sda_desel_free: assert property (
    module_select_n [*4] |-> !sda_dev_oe) else $error("SDA pulled idle");
  a_long_reset_clr: assert property (
    low_ff > 8'h36 |-> !int_oe) else $error("interrupt held in reset");
  a_host_pulse_len: assert property (
    $rose(module_reset_n) |-> low_ff == 8'h64) else $error("pulse length");
  a_done_int_post: assert property (
    $rose(module_reset_n) && low_ff > 8'h34 |-> ##[96:110] int_oe)
    else $error("no completion interrupt");
  a_init_int_quiet: assert property (
    $rose(module_reset_n) |-> !int_oe [*8]) else $error("early interrupt");
  a_host_idle_pins: assert property (
    $rose(rstn) |-> module_select_n && module_reset_n && !sda_host_oe)
    else $error("host pins not idle");
  a_lpm_safe_idle: assert property (
    $rose(rstn) |-> low_power_select) else $error("power mode not low");
  a_present_low: assert property (
    module_present_n == 1'b0) else $error("presence not grounded");
  // Main scenarios reached
  c_host_reset: cover property ($rose(module_reset_n));
  c_int_clear: cover property ($fell(int_oe) && module_reset_n);
  c_sda_pull: cover property (!module_select_n && sda_dev_oe);
endmodule // msc_sva

/* test/test_module_sideband_control.sv */
// Bench joining the host end and the module end
`timescale 1ns/1ns
module test_module_sideband_control;
  `define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin \
    n_mismatch++; $display("FAIL %0t %s", $time, m); end end
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic mgmt_sda_pull = 1'b0, fault_event = 1'b0, int_ack = 1'b0;
  logic select_req = 1'b0, reset_req = 1'b0, low_power_req = 1'b1;
  logic scl_drive = 1'b1, sda_pull = 1'b0;
  logic mgmt_enable, scl_sync, sda_sync, data_not_ready;
  logic low_power_mode, settings_default, present, int_pending;
  logic status_valid, reset_busy, sda_in;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  msc_if pins_if ();
  // ==========
  // Clock, ends and checker
  always #10 core_clk = ~core_clk;
  msc_device msc_device_inst (.core_clk(core_clk), .rstn(rstn),
    .pins(pins_if), .mgmt_enable(mgmt_enable),
    .mgmt_sda_pull(mgmt_sda_pull), .scl_sync(scl_sync),
    .sda_sync(sda_sync), .fault_event(fault_event), .int_ack(int_ack),
    .data_not_ready(data_not_ready), .low_power_mode(low_power_mode),
    .settings_default(settings_default));
  msc_host msc_host_inst (.core_clk(core_clk), .rstn(rstn),
    .pins(pins_if), .select_req(select_req), .reset_req(reset_req),
    .low_power_req(low_power_req), .scl_drive(scl_drive),
    .sda_pull(sda_pull), .present(present), .int_pending(int_pending),
    .status_valid(status_valid), .reset_busy(reset_busy),
    .sda_in(sda_in));
  msc_sva msc_sva_inst (.core_clk(core_clk), .rstn(rstn),
    .module_select_n(pins_if.module_select_n),
    .module_reset_n(pins_if.module_reset_n),
    .low_power_select(pins_if.low_power_select),
    .module_present_n(pins_if.module_present_n),
    .int_oe(pins_if.int_oe), .sda_host_oe(pins_if.sda_host_oe),
    .sda_dev_oe(pins_if.sda_dev_oe));
  // ==========
  // Shared tasks
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // One-cycle pulse, then room for the two sync flops
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(4);
  endtask
  // Bounded wait so a dead interrupt cannot hang the run
  task automatic wait_int();
    for (int i = 0; i < 200; i++) begin
      if (pins_if.module_interrupt_n === 1'b0) break;
      step(1);
    end
    step(4);
    `CHK(pins_if.module_interrupt_n, 1'b0, "no completion interrupt")
    `CHK(data_not_ready, 1'b0, "not-ready still set")
    `CHK(status_valid, 1'b1, "status not valid")
  endtask
  // ==========
  // Scenarios
  task automatic t_powerup();
    wait_int();
    `CHK(present, 1'b1, "module not seen")
  endtask
  task automatic t_int();
    pulse(int_ack);
    `CHK(pins_if.module_interrupt_n, 1'b1, "line not released")
    `CHK(int_pending, 1'b0, "pending after release")
    pulse(fault_event);
    `CHK(int_pending, 1'b1, "fault not flagged")
  endtask
  task automatic t_select();
    select_req = 1'b1;
    mgmt_sda_pull = 1'b1;
    scl_drive = 1'b0;
    step(6);
    `CHK(mgmt_enable, 1'b1, "not enabled")
    `CHK(sda_in, 1'b0, "SDA not pulled")
    `CHK(scl_sync, 1'b0, "SCL not seen")
    select_req = 1'b0;
    step(6);
    `CHK(mgmt_enable, 1'b0, "still enabled")
    `CHK(sda_in, 1'b1, "SDA held deselected")
    // Host pull must reach the module only while it is selected
    mgmt_sda_pull = 1'b0;
    sda_pull = 1'b1;
    step(6);
    `CHK(sda_sync, 1'b1, "host pulled deselected")
    select_req = 1'b1;
    step(6);
    `CHK(sda_sync, 1'b0, "host pull not seen")
    select_req = 1'b0;
    sda_pull = 1'b0;
    scl_drive = 1'b1;
  endtask
  task automatic t_lpm();
    low_power_req = 1'b0;
    step(6);
    `CHK(low_power_mode, 1'b0, "full power not set")
    low_power_req = 1'b1;
    step(6);
    `CHK(low_power_mode, 1'b1, "low power not set")
  endtask
  // Interrupt still pending from the fault, so reset must clear it
  task automatic t_reset();
    pulse(reset_req);
    `CHK(reset_busy, 1'b1, "reset not busy")
    `CHK(status_valid, 1'b0, "status valid in reset")
    step(80);
    `CHK(settings_default, 1'b1, "defaults not restored")
    `CHK(data_not_ready, 1'b1, "not-ready clear")
    `CHK(pins_if.module_interrupt_n, 1'b1, "interrupt in reset")
    wait_int();
    `CHK(settings_default, 1'b0, "stuck in reset")
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard, well above the roughly 380 cycles needed
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    step(10);
    rstn = 1'b1;
    t_powerup();
    t_int();
    t_select();
    t_lpm();
    t_reset();
    final_report();
  end
endmodule // test_module_sideband_control
